// ### sad_conversion_start_n_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sad_conversion_start_n_chk
  import sad_pkg::*;
(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // host pins
  input  wire logic i_chip_select_n,
  input  wire logic i_clock_source_select,
  // device pins
  input  wire logic o_serial_bit_clock,
  input  wire logic o_serial_bit_clock_oe,
  input  wire logic o_data,
  input  wire logic o_data_oe,
  input  wire logic o_busy_n,
  input  wire logic o_sample_hold
);
  logic [8:0] low_cnt;
  logic [8:0] next_low_cnt;
  logic [8:0] gap_cnt;
  logic [8:0] next_gap_cnt;

  // saturating, so a stuck busy cannot wrap back into range
  always_comb
  begin
    next_low_cnt = o_busy_n ? 9'h000 : low_cnt + {8'h00, low_cnt != 9'h1FF};
    next_gap_cnt = o_serial_bit_clock ? 9'h000 : gap_cnt + {8'h00, gap_cnt != 9'h1FF};
  end

  always_ff @(posedge i_ref_clk)
  begin
    low_cnt <= i_resetn ? next_low_cnt : 9'h000;
    gap_cnt <= i_resetn ? next_gap_cnt : 9'h000;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_busy_len: assert property (
    $rose(o_busy_n) |-> low_cnt == BUSY_RISE_CYC) else $error("busy low time wrong");
  chk_busy_max: assert property (
    low_cnt <= BUSY_RISE_CYC) else $error("busy low too long");
  chk_start_hold: assert property (
    $fell(o_busy_n) |-> o_sample_hold) else $error("no hold at start");
  chk_hold_in_busy: assert property (
    o_sample_hold |-> !o_busy_n) else $error("hold outside busy");
  chk_hold_end: assert property (
    $fell(o_sample_hold) |-> ##[1:3] $rose(o_busy_n)) else $error("hold end late");
  chk_idle_low: assert property (
    (o_busy_n && !i_clock_source_select && !$past(i_clock_source_select, 4))
    |-> !o_serial_bit_clock && !o_data) else $error("idle lines not low");
  chk_data_stable: assert property (
    (!i_clock_source_select && (o_serial_bit_clock || $fell(o_serial_bit_clock)))
    |-> $stable(o_data)) else $error("data moved near clock edge");
  chk_half_period: assert property (
    $rose(o_serial_bit_clock) |-> ##9 o_serial_bit_clock ##1 !o_serial_bit_clock)
    else $error("bit clock half period wrong");
  chk_first_rise: assert property (
    ($fell(o_busy_n) && !i_clock_source_select) |-> ##6 $rose(o_serial_bit_clock))
    else $error("first bit clock late");
  chk_last_fall: assert property (
    ($rose(o_busy_n) && !i_clock_source_select && !$past(i_clock_source_select, 8))
    |-> gap_cnt != 9'h000 && gap_cnt <= LAST_FALL_GAP_CYC) else $error("last fall gap");
  chk_oe_follow: assert property (
    $fell(i_chip_select_n) |-> !o_data_oe ##[2:5] o_data_oe) else $error("oe not enabled");
  chk_oe_release: assert property (
    $rose(i_chip_select_n) |-> ##[2:5] !o_data_oe) else $error("oe not released");
  chk_sclk_oe: assert property (
    (i_clock_source_select && $past(i_clock_source_select, 6)) |-> !o_serial_bit_clock_oe)
    else $error("bit clock driven in host mode");

  cover property ($rose(o_busy_n));
  cover property ($fell(o_busy_n) && i_clock_source_select);
  cover property ($rose(o_serial_bit_clock));
endmodule // sad_conversion_start_n_chk

bind sad_conversion_start_n_top sad_conversion_start_n_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_chip_select_n(i_chip_select_n),
  .i_clock_source_select(i_clock_source_select), .o_serial_bit_clock(o_serial_bit_clock),
  .o_serial_bit_clock_oe(o_serial_bit_clock_oe), .o_data(o_data), .o_data_oe(o_data_oe),
  .o_busy_n(o_busy_n), .o_sample_hold(o_sample_hold));
`default_nettype wire

// ### sad_conversion_start_n_top.sv
// Summary of operation
// - start falling edge enters hold, starts conversion
// - start edges ignored during a conversion
// - start works whatever chip select shows
// - busy low from start until completion
// - conversion time, busy rises after completion delay
// - internal clock sends previous result during conversion
// - sixteen bit two's complement, msb first
// - internal data bit stable across both edges
// - busy low over whole internal transmission
// - first rise 0.27 us, period 0.82 us; code gives 0.24 us, 0.80 us
// - last falling edge within 1 us of busy
// - result copied to shift register before busy
// - outputs follow chip select, enable delayed
// - quiet violation keeps old word, drops new
// - select high: host clock; low: device clock
// - internal mode: data and clock low idle
`timescale 1ns/1ns
`default_nettype none
module sad_conversion_start_n_top
  import sad_pkg::*;
(
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  // host control pins
  input  wire logic              i_conversion_start_n,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_clock_source_select,
  // serial bit clock pin, also the link clock in external mode
  input  wire logic              i_serial_bit_clock,
  output var  logic              o_serial_bit_clock,
  output var  logic              o_serial_bit_clock_oe,
  // serial data and busy pins
  output var  logic              o_data,
  output var  logic              o_data_oe,
  output var  logic              o_busy_n,
  output var  logic              o_busy_n_oe,
  // successive approximation core
  input  wire logic [WORD_W-1:0] i_sar_result,
  output var  logic              o_sample_hold
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic start_lvl;
  logic cs_lvl;
  logic sel_lvl;
  logic bclk_lvl;
  logic seen_lvl;

  sad_pin_sync #(.RESET_LVL(RST_START_N)) u_sync_start
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_conversion_start_n),
    .o_lvl     (start_lvl)
  );

  sad_pin_sync #(.RESET_LVL(RST_CS_N)) u_sync_cs
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_chip_select_n),
    .o_lvl     (cs_lvl)
  );

  sad_pin_sync #(.RESET_LVL(RST_SEL)) u_sync_sel
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_clock_source_select),
    .o_lvl     (sel_lvl)
  );

  // level of the host clock, used only for the quiet check
  sad_pin_sync #(.RESET_LVL(RST_BCLK)) u_sync_bclk
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (i_serial_bit_clock),
    .o_lvl     (bclk_lvl)
  );

  // ----------------------------------------------------------------
  // external clock shifter, on the host's clock
  // ----------------------------------------------------------------
  sad_xfer_if xfer ();

  sad_ext_shifter u_ext_shifter
  (
    .i_link_clk (i_serial_bit_clock),
    .i_resetn   (i_resetn),
    .x          (xfer.link)
  );

  // taken mark back from the host clock domain
  sad_pin_sync #(.RESET_LVL(1'b0)) u_sync_seen
  (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_pin     (xfer.seen),
    .o_lvl     (seen_lvl)
  );

  // ----------------------------------------------------------------
  // conversion state
  // ----------------------------------------------------------------
  sad_state_t         state;
  logic [CNT_W-1:0]   cnt;
  logic               start_prev;
  logic               busy_n;
  logic               hold;
  logic               mode_ext;
  logic               quiet_bad;
  logic [WORD_W-1:0]  out_word;
  logic               epoch;
  logic               out_en;
  logic               txing;
  logic [HALF_W-1:0]  half;
  logic [HEDGE_W-1:0] hedge;
  logic [BIT_W-1:0]   bitsel;
  logic               sclk;
  logic               data;

  sad_state_t         next_state;
  logic [CNT_W-1:0]   next_cnt;
  logic               next_busy_n;
  logic               next_hold;
  logic               next_mode_ext;
  logic               next_quiet_bad;
  logic [WORD_W-1:0]  next_out_word;
  logic               next_epoch;
  logic               next_txing;
  logic [HALF_W-1:0]  next_half;
  logic [HEDGE_W-1:0] next_hedge;
  logic [BIT_W-1:0]   next_bitsel;
  logic               next_sclk;
  logic               next_data;
  logic               start_fall;

  // a low pulse of two cycles or more still lands here after the filter; a one-cycle pulse does not
  assign start_fall = start_prev & ~start_lvl;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_busy_n    = busy_n;
    next_hold      = hold;
    next_mode_ext  = mode_ext;
    next_quiet_bad = quiet_bad;
    next_out_word  = out_word;
    next_epoch     = epoch;
    next_txing     = txing;
    next_half      = half;
    next_hedge     = hedge;
    next_bitsel    = bitsel;
    next_sclk      = sclk;
    next_data      = data;
    unique case (state)
      S_IDLE:
      begin
        next_quiet_bad = 1'b0;
        // chip select plays no part in starting
        if (start_fall)
        begin
          next_state    = S_CONVERSION_START_N;
          next_cnt      = '0;
          next_busy_n   = 1'b0;
          next_hold     = 1'b1;
          next_mode_ext = sel_lvl;
        end
      end
      S_CONVERSION_START_N:
      begin
        // start pin is not looked at in this state
        next_cnt = cnt + CNT_W'(1);
        if (!mode_ext && cnt == DATA_SET_CYC)
        begin
          next_data   = out_word[WORD_MSB];
          next_bitsel = WORD_MSB - 4'h1;
        end
        if (!mode_ext && cnt == SCLK_ON_CYC)
        begin
          next_txing = 1'b1;
          next_sclk  = 1'b1;
          next_half  = '0;
          next_hedge = '0;
        end
        // host clock seen high with outputs selected near the end
        if (mode_ext && cnt >= GUARD_CYC && bclk_lvl && !cs_lvl)
        begin
          next_quiet_bad = 1'b1;
        end
        if (cnt == DONE_CYC)
        begin
          next_hold = 1'b0;
          if (!(mode_ext && quiet_bad))
          begin
            next_out_word = i_sar_result;
            // a word not yet begun is replaced in place; toggling
            // again would make it look taken and lose the new one
            if (epoch == seen_lvl)
            begin
              next_epoch = ~epoch;
            end
          end
        end
        if (cnt == END_CYC)
        begin
          next_state  = S_IDLE;
          next_busy_n = 1'b1;
        end
      end
    endcase

    // internal bit clock: fixed half periods of the reference clock
    if (txing)
    begin
      next_half = half + HALF_W'(1);
      if (half == HALF_CYC - HALF_W'(2) && hedge[0] && hedge != LAST_HEDGE)
      begin
        // change one cycle before the rise, long after the fall
        next_data   = out_word[bitsel];
        next_bitsel = bitsel - 4'h1;
      end
      if (half == HALF_CYC - HALF_W'(1))
      begin
        next_half = '0;
        if (hedge == LAST_HEDGE)
        begin
          next_txing = 1'b0;
          next_sclk  = 1'b0;
          next_data  = 1'b0;
        end
        else
        begin
          next_hedge = hedge + HEDGE_W'(1);
          next_sclk  = hedge[0];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      state      <= S_IDLE;
      cnt        <= '0;
      start_prev <= RST_START_N;
      busy_n     <= 1'b1;
      hold       <= 1'b0;
      mode_ext   <= RST_SEL;
      quiet_bad  <= 1'b0;
      out_word   <= RST_WORD;
      epoch      <= 1'b0;
      out_en     <= 1'b0;
      txing      <= 1'b0;
      half       <= '0;
      hedge      <= '0;
      bitsel     <= WORD_LSB;
      sclk       <= 1'b0;
      data       <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      cnt        <= next_cnt;
      start_prev <= start_lvl;
      busy_n     <= next_busy_n;
      hold       <= next_hold;
      mode_ext   <= next_mode_ext;
      quiet_bad  <= next_quiet_bad;
      out_word   <= next_out_word;
      epoch      <= next_epoch;
      // enable lags chip select by the synchroniser, never early
      out_en     <= ~cs_lvl;
      txing      <= next_txing;
      half       <= next_half;
      hedge      <= next_hedge;
      bitsel     <= next_bitsel;
      sclk       <= next_sclk;
      data       <= next_data;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign xfer.word  = out_word;
  assign xfer.epoch = epoch;

  assign o_busy_n              = busy_n;
  assign o_busy_n_oe           = out_en;
  assign o_serial_bit_clock    = sclk;
  assign o_serial_bit_clock_oe = out_en & ~sel_lvl;
  assign o_data                = sel_lvl ? xfer.dout : data;
  assign o_data_oe             = out_en;
  assign o_sample_hold         = hold;

endmodule // sad_conversion_start_n_top
`default_nettype wire

// ### sad_ext_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module sad_ext_shifter
  import sad_pkg::*;
(
  // link clock and reset
  input  wire logic i_link_clk,
  input  wire logic i_resetn,
  // word from the conversion domain
  sad_xfer_if.link  x
);

  logic             rst_meta;
  logic             rst_ok;
  logic             seen;
  logic             live;
  logic [BIT_W-1:0] ptr;
  logic             dout;
  logic             next_seen;
  logic             next_live;
  logic [BIT_W-1:0] next_ptr;
  logic             next_dout;

  assign x.dout = dout;
  assign x.seen = seen;

  // word and epoch only change while the host keeps this clock low
  // for a microsecond, so they are static at every edge seen here
  always_comb
  begin
    next_seen = seen;
    next_live = live;
    next_ptr  = ptr;
    next_dout = 1'b0;
    if (x.epoch != seen)
    begin
      next_seen = x.epoch;
      next_dout = x.word[WORD_MSB];
      next_ptr  = WORD_MSB - 4'h1;
      next_live = 1'b1;
    end
    else if (live)
    begin
      next_dout = x.word[ptr];
      next_ptr  = ptr - 4'h1;
      next_live = (ptr != WORD_LSB);
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    rst_meta <= i_resetn;
    rst_ok   <= rst_meta;
    if (!rst_ok)
    begin
      seen <= 1'b0;
      live <= 1'b0;
      ptr  <= WORD_LSB;
      dout <= 1'b0;
    end
    else
    begin
      seen <= next_seen;
      live <= next_live;
      ptr  <= next_ptr;
      dout <= next_dout;
    end
  end

endmodule // sad_ext_shifter
`default_nettype wire

// ### sad_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sad_host_model
  import sad_pkg::*;
(
  // clock and device data
  input  wire logic i_ref_clk,
  input  wire logic i_data,
  // control pins
  output var  logic o_conversion_start_n,
  output var  logic o_chip_select_n,
  output var  logic o_clock_source_select,
  output var  logic o_serial_bit_clock
);
  time t_last;

  initial
  begin
    t_last = 0;
    o_conversion_start_n = RST_START_N;
    o_chip_select_n = RST_CS_N;
    o_clock_source_select = RST_SEL;
    o_serial_bit_clock = RST_BCLK;
  end

  // early is only used to probe a start that lands inside a conversion
  task automatic start_conversion_start_n(input logic early);
    while (!early && ($time - t_last < 25000)) @(posedge i_ref_clk);
    @(posedge i_ref_clk);
    t_last = $time;
    o_conversion_start_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    o_conversion_start_n <= 1'b1;
  endtask

  task automatic set_pins(input logic cs_n, input logic sel);
    @(posedge i_ref_clk);
    o_chip_select_n <= cs_n;
    o_clock_source_select <= sel;
  endtask

  // link clock runs only inside a read and parks low afterwards
  task automatic read_ext(output logic [WORD_W-1:0] w);
    w = RST_WORD;
    #7;
    repeat (WORD_W)
    begin
      #24 o_serial_bit_clock = 1'b1;
      #24 o_serial_bit_clock = 1'b0;
      w = {w[WORD_W-2:0], i_data};
    end
  endtask

  task automatic park_clock(input logic lvl);
    #11 o_serial_bit_clock = lvl;
  endtask
endmodule // sad_host_model
`default_nettype wire

// ### sad_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sad_pin_sync
  import sad_pkg::*;
#(
  parameter logic RESET_LVL = 1'b0
)(
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // pin and filtered level
  input  wire logic i_pin,
  output var  logic o_lvl
);

  logic s1;
  logic s2;
  logic s3;
  logic next_lvl;

  // level moves only once the last two stages agree
  always_comb
  begin
    next_lvl = (s2 == s3) ? s3 : o_lvl;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_resetn)
    begin
      s1    <= RESET_LVL;
      s2    <= RESET_LVL;
      s3    <= RESET_LVL;
      o_lvl <= RESET_LVL;
    end
    else
    begin
      s1    <= i_pin;
      s2    <= s1;
      s3    <= s2;
      o_lvl <= next_lvl;
    end
  end

endmodule // sad_pin_sync
`default_nettype wire

// ### sad_pkg.sv
`default_nettype none
package sad_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned CNT_W   = 9;
  localparam int unsigned HALF_W  = 4;
  localparam int unsigned HEDGE_W = 5;
  localparam int unsigned BIT_W   = 4;

  localparam logic [BIT_W-1:0] WORD_MSB = BIT_W'(WORD_W - 1);
  localparam logic [BIT_W-1:0] WORD_LSB = 4'h0;

  // ----------------------------------------------------------------
  // times, as printed
  // ----------------------------------------------------------------
  localparam int unsigned REF_CLK_NS         = 40;
  localparam int unsigned T_FIRST_RISE_NS    = 270;
  localparam int unsigned T_BIT_HALF_NS      = 410;
  localparam int unsigned T_DONE_TO_BUSY_NS  = 90;
  localparam int unsigned T_LAST_FALL_MAX_NS = 1000;
  localparam int unsigned T_QUIET_NS         = 1000;

  // ----------------------------------------------------------------
  // cycle counts at the reference clock
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] FIRST_RISE_CYC =
    CNT_W'(T_FIRST_RISE_NS / REF_CLK_NS);
  localparam logic [HALF_W-1:0] HALF_CYC =
    HALF_W'(T_BIT_HALF_NS / REF_CLK_NS);
  localparam logic [CNT_W-1:0] DONE_TO_BUSY_CYC =
    CNT_W'(T_DONE_TO_BUSY_NS / REF_CLK_NS);
  localparam logic [CNT_W-1:0] LAST_FALL_GAP_CYC =
    CNT_W'(T_LAST_FALL_MAX_NS / REF_CLK_NS);
  localparam logic [CNT_W-1:0] QUIET_CYC =
    CNT_W'(T_QUIET_NS / REF_CLK_NS);

  // index of the last half period of the internal bit clock in a word
  localparam logic [HEDGE_W-1:0] LAST_HEDGE = HEDGE_W'(2 * WORD_W - 1);

  // conversion timeline, counted from the cycle after the start edge
  localparam logic [CNT_W-1:0] DATA_SET_CYC  = FIRST_RISE_CYC - CNT_W'(2);
  localparam logic [CNT_W-1:0] SCLK_ON_CYC   = FIRST_RISE_CYC - CNT_W'(1);
  localparam logic [CNT_W-1:0] LAST_FALL_CYC =
    FIRST_RISE_CYC + CNT_W'(LAST_HEDGE) * CNT_W'(HALF_CYC);
  localparam logic [CNT_W-1:0] BUSY_RISE_CYC = LAST_FALL_CYC + LAST_FALL_GAP_CYC;
  localparam logic [CNT_W-1:0] DONE_CYC      = BUSY_RISE_CYC - DONE_TO_BUSY_CYC;
  localparam logic [CNT_W-1:0] GUARD_CYC     = BUSY_RISE_CYC - QUIET_CYC;
  localparam logic [CNT_W-1:0] END_CYC       = BUSY_RISE_CYC - CNT_W'(1);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic              RST_START_N = 1'b1;
  localparam logic              RST_CS_N    = 1'b1;
  localparam logic              RST_SEL     = 1'b0;
  localparam logic              RST_BCLK    = 1'b0;
  localparam logic [WORD_W-1:0] RST_WORD    = 16'h0000;

  typedef enum logic {S_IDLE, S_CONVERSION_START_N} sad_state_t;

endpackage
`default_nettype wire

// ### sad_xfer_if.sv
`timescale 1ns/1ns
`default_nettype none
// result word handed from the conversion domain to the link domain
interface sad_xfer_if;
  import sad_pkg::*;
  logic [WORD_W-1:0] word;
  logic              epoch;
  logic              dout;
  logic              seen;
  modport conversion_start_n (output word, output epoch, input dout, input seen);
  modport link (input word, input epoch, output dout, output seen);
endinterface
`default_nettype wire

// ### test_sar_adc_conversion_serial_readout.sv
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_conversion_serial_readout
  import sad_pkg::*;
;
  logic              clk;
  logic              resetn;
  logic              start_n;
  logic              cs_n;
  logic              sel;
  logic              bclk_host;
  logic              pin_bclk;
  logic              float_lvl;
  logic              sclk;
  logic              sclk_oe;
  logic              data;
  logic              data_oe;
  logic              busy_n;
  logic              busy_oe;
  logic              hold;
  logic              sclk_q;
  logic [WORD_W-1:0] sar;
  logic [WORD_W-1:0] rx;
  int                rx_n;
  int                failures;
  int                tests_run;
  int                cycles;

  // undriven pin keeps moving so a stale level never reads as valid
  assign pin_bclk = sclk_oe ? sclk : (sel ? bclk_host : float_lvl);

  sad_conversion_start_n_top dut (
    .i_ref_clk(clk), .i_resetn(resetn), .i_conversion_start_n(start_n),
    .i_chip_select_n(cs_n), .i_clock_source_select(sel), .i_serial_bit_clock(pin_bclk),
    .o_serial_bit_clock(sclk), .o_serial_bit_clock_oe(sclk_oe), .o_data(data),
    .o_data_oe(data_oe), .o_busy_n(busy_n), .o_busy_n_oe(busy_oe),
    .i_sar_result(sar), .o_sample_hold(hold));

  sad_host_model host (
    .i_ref_clk(clk), .i_data(data), .o_conversion_start_n(start_n),
    .o_chip_select_n(cs_n), .o_clock_source_select(sel), .o_serial_bit_clock(bclk_host));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    float_lvl <= ~pin_bclk;
    sclk_q <= sclk;
    cycles <= cycles + 1;
    if (sclk && !sclk_q)
    begin
      rx <= {rx[WORD_W-2:0], data};
      rx_n <= rx_n + 1;
    end
    if (cycles == 8000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
      $display("wrong value %s expected %h seen %h", what, exp, got);
    if (got !== exp)
      failures++;
  endtask

  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy_n !== lvl && n < 400)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic conversion_start_n(input logic [WORD_W-1:0] res, input logic restart, output int len);
    int n;
    sar <= res;
    host.start_conversion_start_n(1'b0);
    wait_busy(1'b0, n);
    check("hold at start", 16'h0001, {15'h0000, hold});
    len = 0;
    if (restart)
    begin
      repeat (100) @(posedge clk);
      host.start_conversion_start_n(1'b1);
      len = 104;
    end
    wait_busy(1'b1, n);
    len += n;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_internal();
    int len;
    int n0;
    check("idle busy", 16'h0001, {15'h0000, busy_n});
    conversion_start_n(16'h8001, 1'b0, len);
    check("busy len cs high", 16'(BUSY_RISE_CYC), 16'(len));
    check("oe with cs high", 16'h0000, {14'h0000, busy_oe, data_oe});
    host.set_pins(1'b0, 1'b0);
    repeat (6) @(posedge clk);
    check("oe with cs low", 16'h0003, {14'h0000, busy_oe, data_oe});
    n0 = rx_n;
    conversion_start_n(16'h7FFE, 1'b1, len);
    check("busy len restart", 16'(BUSY_RISE_CYC), 16'(len));
    check("bit count", 16'(WORD_W), 16'(rx_n - n0));
    check("internal word", 16'h8001, rx);
  endtask

  task automatic s_ext_read();
    int len;
    logic [WORD_W-1:0] w;
    host.set_pins(1'b0, 1'b1);
    repeat (6) @(posedge clk);
    check("bclk oe", 16'h0000, {15'h0000, sclk_oe});
    conversion_start_n(16'h1234, 1'b0, len);
    host.read_ext(w);
    check("external word", 16'h1234, w);
  endtask

  task automatic s_quiet_drop();
    int len;
    int n;
    logic [WORD_W-1:0] w;
    conversion_start_n(16'h5A5A, 1'b0, len);
    sar <= 16'hABCD;
    host.start_conversion_start_n(1'b0);
    repeat (60) @(posedge clk);
    host.park_clock(1'b1);
    wait_busy(1'b1, n);
    host.park_clock(1'b0);
    host.read_ext(w);
    check("kept word", 16'hB4B4, w);
    host.set_pins(1'b1, 1'b1);
    repeat (6) @(posedge clk);
    check("oe after cs high", 16'h0000, {14'h0000, busy_oe, data_oe});
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    failures = 0;
    tests_run = 0;
    cycles = 0;
    rx_n = 0;
    rx = 16'h0000;
    sclk_q = 1'b0;
    float_lvl = 1'b0;
    sar = 16'h0000;
    resetn = 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    s_internal();
    s_ext_read();
    s_quiet_drop();
    summarize();
  end
endmodule // test_sar_adc_conversion_serial_readout
`default_nettype wire
